// ===== design/ref_comp_pkg.sv
package ref_comp_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_CH = 8;
   localparam int CNT_W = 16;
   localparam int IDX_W = 3;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_ACTIVE = 8'h06;
   localparam logic [7:0] ADDR_GLOBAL = 8'h87;
   localparam logic [7:0] ADDR_SUPP = 8'h88;
   localparam logic [7:0] ADDR_THR = 8'h97;
   localparam logic [7:0] ADDR_MASK = 8'h99;

   // ==========================================================
   // Field positions
   localparam int DRIFT_BIT = 12;
   localparam int LEVEL_LSB = 14;
   localparam int LEVEL_W = 2;
   localparam int PROX_THR_LSB = 0;
   localparam int TOUCH_THR_LSB = 8;
   localparam int THR_W = 8;
   localparam int ASSOC_LSB = 0;
   localparam int REF_IDX_LSB = 8;
   localparam int REF_EN_BIT = 11;

   // ==========================================================
   // Reset values and the one-hot base
   localparam logic [15:0] GLOBAL_RST = 16'h0000;
   localparam logic [15:0] SUPP_RST = 16'h0000;
   localparam logic [15:0] THR_RST = 16'h2010;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [7:0] ONE_HOT_BASE = 8'h01;

   // ==========================================================
   // Types
   typedef enum {MODE_RESYNC, MODE_SUPPRESS, MODE_DRIFT} comp_mode_e;

   typedef struct packed {
      logic deep;
      logic touch;
      logic prox;
   } ch_state_s;

   typedef struct packed {
      logic [NUM_CH-1:0] resync;
      logic [NUM_CH-1:0] track;
      logic [NUM_CH-1:0] supp_prox;
      logic [NUM_CH-1:0] supp_touch;
   } action_s;
endpackage

// ===== design/reference_channel_compensation.sv
`timescale 1ns/100ps
module reference_channel_compensation
#(
   parameter int NUM_CH = ref_comp_pkg::NUM_CH
)
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   output logic [15:0] reg_rdata_out,
   output logic reg_rvalid_out,
   input wire logic sample_in,
   input wire logic [NUM_CH-1:0][ref_comp_pkg::CNT_W-1:0] delta_in,
   input wire ref_comp_pkg::ch_state_s [NUM_CH-1:0] ch_state_in,
   output ref_comp_pkg::action_s action_out,
   output logic [ref_comp_pkg::CNT_W-1:0] track_delta_out,
   output logic ref_event_out,
   output logic [NUM_CH-1:0] active_ref_out
);

   // ==========================================================
   // Configuration registers
   logic [15:0] global_reg;
   logic [15:0] supp_reg;
   logic [15:0] thr_reg;
   logic [15:0] mask_reg;

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         global_reg <= ref_comp_pkg::GLOBAL_RST;
         supp_reg <= ref_comp_pkg::SUPP_RST;
         thr_reg <= ref_comp_pkg::THR_RST;
         mask_reg <= ref_comp_pkg::MASK_RST;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            ref_comp_pkg::ADDR_GLOBAL: global_reg <= reg_wdata_in;
            ref_comp_pkg::ADDR_SUPP: supp_reg <= reg_wdata_in;
            ref_comp_pkg::ADDR_THR: thr_reg <= reg_wdata_in;
            ref_comp_pkg::ADDR_MASK: mask_reg <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // Reads answer one cycle later; unmapped addresses read as zero
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         reg_rdata_out <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in)
         begin
            case (reg_addr_in)
               ref_comp_pkg::ADDR_ACTIVE: reg_rdata_out <= {8'h00, active_ref_out};
               ref_comp_pkg::ADDR_GLOBAL: reg_rdata_out <= global_reg;
               ref_comp_pkg::ADDR_SUPP: reg_rdata_out <= supp_reg;
               ref_comp_pkg::ADDR_THR: reg_rdata_out <= thr_reg;
               ref_comp_pkg::ADDR_MASK: reg_rdata_out <= mask_reg;
               default: reg_rdata_out <= 16'h0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Field decode
   logic [NUM_CH-1:0] assoc;
   logic [ref_comp_pkg::IDX_W-1:0] ref_idx;
   logic ref_en;
   logic [ref_comp_pkg::LEVEL_W-1:0] level;
   logic [ref_comp_pkg::THR_W-1:0] prox_thr;
   logic [ref_comp_pkg::THR_W-1:0] touch_thr;
   logic [NUM_CH-1:0] ref_onehot;
   ref_comp_pkg::comp_mode_e mode;

   assign assoc = mask_reg[ref_comp_pkg::ASSOC_LSB +: NUM_CH];
   assign ref_idx = mask_reg[ref_comp_pkg::REF_IDX_LSB +: ref_comp_pkg::IDX_W];
   assign ref_en = mask_reg[ref_comp_pkg::REF_EN_BIT];
   assign level = global_reg[ref_comp_pkg::LEVEL_LSB +: ref_comp_pkg::LEVEL_W];
   assign prox_thr = thr_reg[ref_comp_pkg::PROX_THR_LSB +: ref_comp_pkg::THR_W];
   assign touch_thr = thr_reg[ref_comp_pkg::TOUCH_THR_LSB +: ref_comp_pkg::THR_W];
   assign ref_onehot = NUM_CH'(ref_comp_pkg::ONE_HOT_BASE << ref_idx);

   // Drift following overrides the per-channel suppression choice
   always_comb
   begin
      if (global_reg[ref_comp_pkg::DRIFT_BIT])
         mode = ref_comp_pkg::MODE_DRIFT;
      else if (supp_reg[ref_idx])
         mode = ref_comp_pkg::MODE_SUPPRESS;
      else
         mode = ref_comp_pkg::MODE_RESYNC;
   end

   // ==========================================================
   // Reference threshold tracking, updated once per sample
   logic [ref_comp_pkg::CNT_W-1:0] ref_delta;
   logic [ref_comp_pkg::CNT_W-1:0] prev_delta;
   logic [ref_comp_pkg::CNT_W-1:0] change;
   logic next_prox;
   logic next_touch;
   logic ref_prox;
   logic ref_touch;
   logic prox_rise;

   assign ref_delta = delta_in[ref_idx];
   assign next_prox = ref_en
      && ($signed(ref_delta) >= $signed({{(ref_comp_pkg::CNT_W-ref_comp_pkg::THR_W){1'b0}}, prox_thr}));
   assign next_touch = ref_en
      && ($signed(ref_delta) >= $signed({{(ref_comp_pkg::CNT_W-ref_comp_pkg::THR_W){1'b0}}, touch_thr}));
   assign prox_rise = sample_in && next_prox && !ref_prox;
   assign change = ref_comp_pkg::CNT_W'(ref_delta - prev_delta);

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         ref_prox <= 1'b0;
         ref_touch <= 1'b0;
         prev_delta <= '0;
      end
      else if (sample_in)
      begin
         ref_prox <= next_prox;
         ref_touch <= next_touch;
         prev_delta <= ref_delta;
      end
   end

   // ==========================================================
   // Per-channel level compare
   logic [NUM_CH-1:0] at_or_below;

   generate
      for (genvar i = 0; i < NUM_CH; i++)
      begin : g_level
         logic [ref_comp_pkg::LEVEL_W-1:0] ch_level;
         always_comb
         begin
            if (ch_state_in[i].deep)
               ch_level = 2'h3;
            else if (ch_state_in[i].touch)
               ch_level = 2'h2;
            else if (ch_state_in[i].prox)
               ch_level = 2'h1;
            else
               ch_level = 2'h0;
         end
         assign at_or_below[i] = (ch_level <= level);
      end
   endgenerate

   // ==========================================================
   // Actions
   ref_comp_pkg::action_s next_action;
   logic supp_on;
   logic supp_on_q;
   logic next_event;

   // Suppression is a level; its start counts as an applied change
   assign supp_on = (mode == ref_comp_pkg::MODE_SUPPRESS) && (ref_prox || ref_touch);

   always_comb
   begin
      next_action = '0;
      if (prox_rise && mode == ref_comp_pkg::MODE_RESYNC)
         next_action.resync = assoc;
      if (prox_rise && mode == ref_comp_pkg::MODE_DRIFT)
         next_action.resync = assoc & at_or_below;
      if (sample_in && ref_en && mode == ref_comp_pkg::MODE_DRIFT && change != '0)
         next_action.track = assoc & ~at_or_below;
      if (mode == ref_comp_pkg::MODE_SUPPRESS && ref_prox)
         next_action.supp_prox = assoc;
      if (mode == ref_comp_pkg::MODE_SUPPRESS && ref_touch)
         next_action.supp_touch = assoc;
   end

   assign next_event = (|next_action.resync) || (|next_action.track)
      || (supp_on && !supp_on_q && (|assoc));

   // The front end loads the baseline from its filtered count on a resync strobe
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         action_out <= '0;
         track_delta_out <= '0;
      end
      else
      begin
         action_out <= next_action;
         if (|next_action.track)
            track_delta_out <= change;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
      begin
         ref_event_out <= 1'b0;
         supp_on_q <= 1'b0;
      end
      else
      begin
         ref_event_out <= next_event;
         supp_on_q <= supp_on;
      end
   end

   // A new event wins over the clear when the reference goes idle
   always_ff @(posedge clk_sys_in)
   begin
      if (srst_in)
         active_ref_out <= '0;
      else if (next_event)
         active_ref_out <= ref_onehot;
      else if (!ref_prox && !ref_touch)
         active_ref_out <= '0;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);

   sequence s_rise_resync;
      prox_rise && mode == ref_comp_pkg::MODE_RESYNC;
   endsequence

   sequence s_supp_prox;
      mode == ref_comp_pkg::MODE_SUPPRESS && ref_prox;
   endsequence

   chk_reset_mode_resync: assert property ($past(srst_in) |-> mode == ref_comp_pkg::MODE_RESYNC)
      else $error("mode not resync after reset");
   chk_mask_limits_actions: assert property (1'b1 |=>
      ((action_out.resync | action_out.track) & ~$past(assoc)) == '0)
      else $error("action outside associated mask");
   chk_level_field_drift: assert property ($past(mode) == ref_comp_pkg::MODE_DRIFT
      |-> (action_out.resync & ~$past(at_or_below)) == '0)
      else $error("resync above selected level");
   chk_rise_resyncs_all: assert property (s_rise_resync |=> action_out.resync == $past(assoc))
      else $error("resync mask wrong on crossing");
   chk_select_suppress: assert property (!global_reg[ref_comp_pkg::DRIFT_BIT]
      && supp_reg[ref_idx] |-> mode == ref_comp_pkg::MODE_SUPPRESS)
      else $error("suppress selection ignored");
   chk_suppress_prox_held: assert property (s_supp_prox |=> action_out.supp_prox == $past(assoc))
      else $error("proximity events not suppressed");
   chk_drift_bit_mode: assert property (global_reg[ref_comp_pkg::DRIFT_BIT]
      |-> mode == ref_comp_pkg::MODE_DRIFT)
      else $error("drift bit ignored");
   chk_resync_needs_rise: assert property (|action_out.resync |-> $past(prox_rise))
      else $error("resync without reference crossing");
   chk_active_on_event: assert property (ref_event_out |-> active_ref_out == $past(ref_onehot))
      else $error("active bitmap not set on event");
   chk_event_on_apply: assert property ((|next_action.resync) || (|next_action.track)
      |=> ref_event_out)
      else $error("reference event flag missing");
   chk_track_delta_value: assert property (|action_out.track |-> track_delta_out == $past(change))
      else $error("track delta mismatch");

endmodule

// ===== bench/host_model.sv
`timescale 1ns/100ps
// ==========
// Host side of the register port
module host_model
(
   input wire logic clk_sys_in,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_addr_out,
   output logic [15:0] reg_wdata_out
);
   initial
   begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 16'h0000;
   end

   // One word per strobe; the host picks the mask bits it wants
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk_sys_in);
      reg_wr_out = wr;
      reg_rd_out = !wr;
      reg_addr_out = a;
      reg_wdata_out = d;
      @(negedge clk_sys_in);
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      // Released lines must not keep showing the old value
      reg_addr_out = ~a;
      reg_wdata_out = ~d;
   endtask
endmodule

// ===== bench/reference_channel_compensation_bench.sv
`timescale 1ns/100ps
module reference_channel_compensation_bench;
   logic clk_sys_in, srst_in, reg_wr, reg_rd, reg_rvalid, sample_in, ref_event, samp_d;
   logic [7:0] reg_addr, m, active_ref;
   logic [15:0] reg_wdata, reg_rdata, track_delta;
   logic [7:0][15:0] delta;
   ref_comp_pkg::ch_state_s [7:0] ch_state;
   ref_comp_pkg::action_s action;
   int failures, n_checks;
   logic [31:0] rnd = 32'h0000001C;
   logic [15:0] rd_q[$];
   logic [16:0] act_q[$];

   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   host_model i_host_model (.clk_sys_in(clk_sys_in), .reg_wr_out(reg_wr),
      .reg_rd_out(reg_rd), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata));

   reference_channel_compensation i_reference_channel_compensation (.clk_sys_in(clk_sys_in),
      .srst_in(srst_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid),
      .sample_in(sample_in), .delta_in(delta), .ch_state_in(ch_state), .action_out(action),
      .track_delta_out(track_delta), .ref_event_out(ref_event), .active_ref_out(active_ref));

   function automatic logic [31:0] xorshift();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      i_host_model.xfer(1'b0, a, 16'h0000);
   endtask

   // Reference channel is 3; the others carry random noise
   task automatic samp(input logic [15:0] d3, input logic [16:0] exp);
      @(negedge clk_sys_in);
      for (int i = 0; i < 8; i++)
         delta[i] = {8'h00, 8'(xorshift())};
      delta[3] = d3;
      sample_in = 1'b1;
      act_q.push_back(exp);
      @(negedge clk_sys_in);
      sample_in = 1'b0;
   endtask

   // ==========
   // Result watcher
   always @(posedge clk_sys_in)
      samp_d <= sample_in;

   always @(negedge clk_sys_in)
   begin
      if (reg_rvalid === 1'b1)
         check({1'b0, reg_rdata}, {1'b0, rd_q.pop_front()});
      if (samp_d === 1'b1)
         check({ref_event, action.resync, action.track}, act_q.pop_front());
   end

   initial
   begin
      #200000;
      failures++;
      close_out();
   end

   // ==========
   // Main sequence
   initial
   begin
      srst_in = 1'b1;
      sample_in = 1'b0;
      delta = '0;
      ch_state = '0;
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      srst_in = 1'b0;
      i_host_model.xfer(1'b1, 8'h06, 16'hFFFF);
      rd(8'h87, 16'h0000);
      rd(8'h88, 16'h0000);
      rd(8'h97, 16'h2010);
      rd(8'h99, 16'h0000);
      rd(8'h06, 16'h0000);
      rd(8'h10, 16'h0000);
      $display("test registers done");
      m = (8'(xorshift()) & 8'hF7) | 8'h01;
      i_host_model.xfer(1'b1, 8'h99, {8'h0B, m});
      rd(8'h99, {8'h0B, m});
      samp(16'h0010, {1'b1, m, 8'h00});
      check({9'h000, active_ref}, 17'h00008);
      samp(16'h0000, 17'h00000);
      $display("test resync done");
      i_host_model.xfer(1'b1, 8'h88, 16'h0008);
      // Suppression starts one cycle after the sample edge, so its event pulse lags by one more
      samp(16'h0020, 17'h00000);
      @(negedge clk_sys_in);
      check({16'h0000, ref_event}, 17'h00001);
      @(negedge clk_sys_in);
      check({1'b0, action.supp_prox, action.supp_touch}, {1'b0, m, m});
      samp(16'h0000, 17'h00000);
      repeat (2) @(negedge clk_sys_in);
      check({1'b0, action.supp_prox, action.supp_touch}, 17'h00000);
      $display("test suppress done");
      i_host_model.xfer(1'b1, 8'h88, 16'h0000);
      ch_state[0].prox = 1'b1;
      for (int l = 0; l < 4; l++)
      begin
         i_host_model.xfer(1'b1, 8'h87, {l[1:0], 14'h1000});
         samp(16'h0010, {1'b1, m & ((l >= 1) ? 8'hFF : 8'hFE),
            (l >= 1) ? 8'h00 : 8'h01});
         if (l == 0)
            check({1'b0, track_delta}, 17'h00010);
         samp(16'h0000, {(l == 0), 8'h00, (l == 0) ? 8'h01 : 8'h00});
      end
      $display("test drift done");
      repeat (3) @(negedge clk_sys_in);
      close_out();
   end
endmodule
